// ---- ifb_bank.sv ----
/*
 * Interrupt request flag and enable bank with edge qualified pins,
 * timer groups, global enable, fixed priority and wake detection.
 * Assumes all inputs are synchronous to I_CLK and that the core pulses
 * I_IRQ_ACK for one cycle when it enters the service shown on O_IRQ_VEC.
 */
`timescale 1ns/100ps
module ifb_bank #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire ifb_pkg::ifb_req_t I_REG,
	input wire ifb_pkg::ifb_evt_t I_EVT,
	input wire logic I_IRQ_ACK,
	output logic [7:0] O_RDATA,
	output logic O_IRQ_REQ,
	output logic [3:0] O_IRQ_VEC,
	output logic O_WAKE
);
	import ifb_pkg::*;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	logic [7:0] regs_r [IFB_NREG];
	logic [7:0] regs_nxt [IFB_NREG];
	logic [7:0] set_v [IFB_NREG];
	logic [1:0] pin_prev_r;
	logic [IFB_NSRC-1:0] flg;
	logic [IFB_NSRC-1:0] en;
	logic [7:0] rdata_nxt;
	logic req_nxt;
	logic [3:0] vec_nxt;
	logic wake_nxt;

	// Implemented bits of each register; index 7 holds nothing.
	function automatic logic [7:0] reg_mask(input logic [2:0] idx);
		case (idx)
			IFB_IDX_EDGE: reg_mask = IFB_MASK_EDGE;
			IFB_IDX_CA: reg_mask = IFB_MASK_CA;
			IFB_IDX_CC: reg_mask = LARGE_VARIANT ? IFB_MASK_FULL :
				IFB_MASK_CC_SMALL;
			3'h7: reg_mask = IFB_RST_VAL;
			default: reg_mask = IFB_MASK_FULL;
		endcase
	endfunction : reg_mask

	// Edge qualifier shared by both external pins.
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic cur, input logic prev);
		case (sel)
			IFB_EDGE_RISE: edge_hit = cur & ~prev;
			IFB_EDGE_FALL: edge_hit = ~cur & prev;
			IFB_EDGE_BOTH: edge_hit = cur ^ prev;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Per-source flag and enable views, taken from the stored registers.
	always_comb begin
		for (int s = 0; s < IFB_NSRC; s++) begin
			flg[s] = regs_r[IFB_SRC_REG[s]][IFB_SRC_FBIT[s]];
			en[s] = regs_r[IFB_SRC_REG[s]][IFB_SRC_EBIT[s]];
		end
	end

	// Hardware set requests for every register bit.
	always_comb begin
		for (int r = 0; r < IFB_NREG; r++) begin
			set_v[r] = IFB_RST_VAL;
		end
		set_v[IFB_IDX_CA][IFB_BIT_PIN0_F] = edge_hit( // [RULE_02]
			regs_r[IFB_IDX_EDGE][IFB_BIT_PIN0_SEL +: 2],
			I_EVT.pin[0], pin_prev_r[0]);
		set_v[IFB_IDX_CB][IFB_BIT_PIN1_F] = edge_hit( // [RULE_01]
			regs_r[IFB_IDX_EDGE][IFB_BIT_PIN1_SEL +: 2],
			I_EVT.pin[1], pin_prev_r[1]);
		set_v[IFB_IDX_CA][6:5] = {I_EVT.tbase[1], I_EVT.tbase[0]}; // [RULE_06]
		set_v[IFB_IDX_CB][6:5] = {I_EVT.adc, I_EVT.eeprom}; // [RULE_07]
		set_v[IFB_IDX_CC][6] = I_EVT.sim; // [RULE_08]
		set_v[IFB_IDX_CC][7] = I_EVT.uart & LARGE_VARIANT; // [RULE_09]
		// Timer members land in the high nibble of each group register.
		for (int g = 0; g < 3; g++) begin
			set_v[IFB_IDX_MFA + 3'(g)][7:4] = I_EVT.tmr[g*4 +: 4]; // [RULE_10]
		end
		// Group flags follow any enabled pending member.
		set_v[IFB_IDX_CB][IFB_BIT_GRP_F] = |(regs_r[IFB_IDX_MFA][7:4] &
			regs_r[IFB_IDX_MFA][3:0]); // [RULE_15]
		set_v[IFB_IDX_CC][IFB_BIT_GRP_F] = |(regs_r[IFB_IDX_MFB][7:4] &
			regs_r[IFB_IDX_MFB][3:0]); // [RULE_15]
		set_v[IFB_IDX_CC][IFB_BIT_GRP_F+1] = |(regs_r[IFB_IDX_MFC][7:4] &
			regs_r[IFB_IDX_MFC][3:0]); // [RULE_15]
	end

	// Next register values: write, then service clears, then sets win.
	always_comb begin
		wake_nxt = 1'b0;
		for (int r = 0; r < IFB_NREG; r++) begin
			regs_nxt[r] = regs_r[r];
			if (I_REG.wr && I_REG.idx == 3'(r)) begin
				regs_nxt[r] = I_REG.wdata; // [RULE_16]
			end
			if (I_IRQ_ACK && O_IRQ_REQ) begin
				if (r == int'(IFB_IDX_CA)) begin
					regs_nxt[r][IFB_BIT_GLB_EN] = 1'b0; // [RULE_13]
				end
				if (IFB_SRC_REG[O_IRQ_VEC] == 3'(r)) begin
					regs_nxt[r][IFB_SRC_FBIT[O_IRQ_VEC]] = 1'b0;
				end
			end
			regs_nxt[r] = (regs_nxt[r] | set_v[r]) & reg_mask(3'(r)); // [RULE_03] [RULE_05]
			if (r != int'(IFB_IDX_EDGE)) begin
				wake_nxt = wake_nxt | (|(set_v[r] & ~regs_r[r] &
					IFB_FLAG_BITS & reg_mask(3'(r)))); // [RULE_14]
			end
		end
	end

	// Fixed priority pick and global gate of the service request.
	always_comb begin
		vec_nxt = 4'h0;
		for (int s = IFB_NSRC - 1; s >= 0; s--) begin
			if (flg[s] && en[s]) begin // [RULE_11] [RULE_12]
				vec_nxt = 4'(s); // [RULE_15]
			end
		end
		req_nxt = regs_r[IFB_IDX_CA][IFB_BIT_GLB_EN] & (|(flg & en)) &
			~I_IRQ_ACK; // [RULE_04]
		rdata_nxt = (I_REG.idx < 3'(IFB_NREG)) ? regs_r[I_REG.idx] :
			IFB_RST_VAL;
	end

	// State and output registers.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			for (int r = 0; r < IFB_NREG; r++) begin
				regs_r[r] <= IFB_RST_VAL; // [RULE_16]
			end
			pin_prev_r <= 2'h0;
			O_RDATA <= IFB_RST_VAL;
			O_IRQ_REQ <= 1'b0;
			O_IRQ_VEC <= 4'h0;
			O_WAKE <= 1'b0;
		end else begin
			regs_r <= regs_nxt;
			pin_prev_r <= I_EVT.pin;
			O_RDATA <= rdata_nxt;
			O_IRQ_REQ <= req_nxt;
			O_IRQ_VEC <= vec_nxt;
			O_WAKE <= wake_nxt;
		end
	end

	// Writes to the first primary register, excluded where it matters.
	logic wr_ca;
	assign wr_ca = I_REG.wr && I_REG.idx == IFB_IDX_CA;

	property p_pin1_rise;
		regs_r[IFB_IDX_EDGE][3:2] == IFB_EDGE_RISE && I_EVT.pin[1] &&
			!pin_prev_r[1] |=> regs_r[IFB_IDX_CB][IFB_BIT_PIN1_F];
	endproperty
	a_pin1_rise: assert property (p_pin1_rise) // [RULE_01]
		else $error("pin 1 rising edge did not set its flag");

	property p_pin0_off;
		regs_r[IFB_IDX_EDGE][1:0] == IFB_EDGE_OFF && !wr_ca &&
			!regs_r[IFB_IDX_CA][IFB_BIT_PIN0_F]
			|=> !regs_r[IFB_IDX_CA][IFB_BIT_PIN0_F];
	endproperty
	a_pin0_off: assert property (p_pin0_off) // [RULE_02]
		else $error("pin 0 flag set while its edge select is off");

	property p_unimpl;
		regs_r[IFB_IDX_EDGE][7:4] == 4'h0 && !regs_r[IFB_IDX_CA][7] &&
			(LARGE_VARIANT || (regs_r[IFB_IDX_CC] & 8'h88) == 8'h00);
	endproperty
	a_unimpl: assert property (p_unimpl) // [RULE_03]
		else $error("unimplemented bit holds a one");

	property p_glb_gate;
		!regs_r[IFB_IDX_CA][IFB_BIT_GLB_EN] |=> !O_IRQ_REQ;
	endproperty
	a_glb_gate: assert property (p_glb_gate) // [RULE_04]
		else $error("request raised with global enable clear");

	property p_adc_set;
		I_EVT.adc |=> regs_r[IFB_IDX_CB][6];
	endproperty
	a_adc_set: assert property (p_adc_set) // [RULE_05]
		else $error("converter event lost");

	property p_tb1_set;
		I_EVT.tbase[1] |=> regs_r[IFB_IDX_CA][6];
	endproperty
	a_tb1_set: assert property (p_tb1_set) // [RULE_06]
		else $error("time base 1 event lost");

	property p_eep_set;
		I_EVT.eeprom |=> regs_r[IFB_IDX_CB][5];
	endproperty
	a_eep_set: assert property (p_eep_set) // [RULE_07]
		else $error("EEPROM event lost");

	property p_sim_set;
		I_EVT.sim |=> regs_r[IFB_IDX_CC][6];
	endproperty
	a_sim_set: assert property (p_sim_set) // [RULE_08]
		else $error("serial module event lost");

	property p_uart_set;
		I_EVT.uart |=> regs_r[IFB_IDX_CC][7] == LARGE_VARIANT;
	endproperty
	a_uart_set: assert property (p_uart_set) // [RULE_09]
		else $error("UART flag does not follow the variant");

	property p_tmr_set;
		I_EVT.tmr[8] |=> regs_r[IFB_IDX_MFC][4];
	endproperty
	a_tmr_set: assert property (p_tmr_set) // [RULE_10]
		else $error("compact timer member event lost");

	property p_en_block;
		(flg & en) == '0 |=> !O_IRQ_REQ;
	endproperty
	a_en_block: assert property (p_en_block) // [RULE_11]
		else $error("request raised with no enabled flag");

	property p_hold_masked;
		flg[4] && !en[4] && !(I_REG.wr && I_REG.idx == IFB_IDX_CB)
			|=> flg[4];
	endproperty
	a_hold_masked: assert property (p_hold_masked) // [RULE_12]
		else $error("masked converter flag was dropped");

	property p_ack_glb;
		I_IRQ_ACK && O_IRQ_REQ && !wr_ca
			|=> !regs_r[IFB_IDX_CA][IFB_BIT_GLB_EN] && !O_IRQ_REQ;
	endproperty
	a_ack_glb: assert property (p_ack_glb) // [RULE_13]
		else $error("service entry left global enable set");

	property p_wake;
		I_EVT.adc && !regs_r[IFB_IDX_CB][6] |=> O_WAKE;
	endproperty
	a_wake: assert property (p_wake) // [RULE_14]
		else $error("new flag did not wake the device");

	property p_group;
		regs_r[IFB_IDX_MFA][4] && regs_r[IFB_IDX_MFA][0]
			|=> regs_r[IFB_IDX_CB][IFB_BIT_GRP_F];
	endproperty
	a_group: assert property (p_group) // [RULE_15]
		else $error("group 0 flag not set by enabled member");

	property p_reset;
		disable iff (1'b0) I_SYS_RST |=> regs_r[IFB_IDX_CB] == 8'h00 &&
			!O_IRQ_REQ;
	endproperty
	a_reset: assert property (p_reset) // [RULE_16]
		else $error("register not cleared by reset");

endmodule : ifb_bank

// ---- ifb_pkg.sv ----
/*
 * Constants, register map and carrier types of the interrupt flag and
 * enable bank.
 * Assumes the processor core reaches the bank as special data memory
 * through a plain select, write strobe and data port on the system clock.
 */
// Operation
// RULE_01: Pin 1 edge select 00 turns the pin off, 01 catches rising, 10 falling and 11 both edges.
// RULE_02: Pin 0 edge select, the low two bits, uses the same encoding as pin 1.
// RULE_03: Unimplemented bits of the edge, primary and small third control registers read zero and ignore writes.
// RULE_04: Bit 0 of the first primary control register is the global enable and, when clear, blocks every request.
// RULE_05: A source's trigger sets its request flag to 1, and each flag pairs with a software enable.
// RULE_06: The first primary register holds time base 1, time base 0 and pin 0 flags at bits 6..4 and enables at 3..1.
// RULE_07: The second primary register holds pin 1, converter, EEPROM and group 0 flags at 7..4 and enables at 3..0.
// RULE_08: The third primary register holds serial, group 2 and group 1 flags at 6..4 and enables at 2..0.
// RULE_09: The larger variant adds a UART flag at bit 7 and enable at bit 3 of the third primary register.
// RULE_10: Three group registers each hold four timer comparator flags at 7..4 and enables at 3..0.
// RULE_11: An enable of 0 blocks its source and 1 lets it through, subject to the global enable.
// RULE_12: A set flag with a clear enable stays recorded but never raises a request.
// RULE_13: Entering a service clears the global enable, while new events still set their flags.
// RULE_14: A flag turning from 0 to 1 wakes the device, and a flag already set does not.
// RULE_15: A group flag sets while any member flag and its enable are both set, and sources win by fixed priority.
// RULE_16: All implemented bits clear to zero at reset and software can read and write each of them.
package ifb_pkg;

	// Register indices in the special data memory window.
	localparam logic [2:0] IFB_IDX_EDGE = 3'h0;
	localparam logic [2:0] IFB_IDX_CA = 3'h1;
	localparam logic [2:0] IFB_IDX_CB = 3'h2;
	localparam logic [2:0] IFB_IDX_CC = 3'h3;
	localparam logic [2:0] IFB_IDX_MFA = 3'h4;
	localparam logic [2:0] IFB_IDX_MFB = 3'h5;
	localparam logic [2:0] IFB_IDX_MFC = 3'h6;
	localparam int IFB_NREG = 7;
	localparam int IFB_NSRC = 11;

	// Implemented bit masks and the common reset value.
	localparam logic [7:0] IFB_MASK_EDGE = 8'h0f;
	localparam logic [7:0] IFB_MASK_CA = 8'h7f;
	localparam logic [7:0] IFB_MASK_CC_SMALL = 8'h77;
	localparam logic [7:0] IFB_MASK_FULL = 8'hff;
	localparam logic [7:0] IFB_FLAG_BITS = 8'hf0;
	localparam logic [7:0] IFB_RST_VAL = 8'h00;

	// Field positions.
	localparam int IFB_BIT_GLB_EN = 0;
	localparam int IFB_BIT_PIN0_SEL = 0;
	localparam int IFB_BIT_PIN1_SEL = 2;
	localparam int IFB_BIT_PIN0_F = 4;
	localparam int IFB_BIT_PIN1_F = 7;
	localparam int IFB_BIT_GRP_F = 4;
	localparam int IFB_MF_MEMBERS = 4;

	// Edge select encodings.
	localparam logic [1:0] IFB_EDGE_OFF = 2'h0;
	localparam logic [1:0] IFB_EDGE_RISE = 2'h1;
	localparam logic [1:0] IFB_EDGE_FALL = 2'h2;
	localparam logic [1:0] IFB_EDGE_BOTH = 2'h3;

	// Sources in priority order, index 0 highest: pin 0, pin 1, time
	// base 0, time base 1, converter, EEPROM, group 0, 1, 2, serial, UART.
	localparam logic [2:0] IFB_SRC_REG [IFB_NSRC] = '{3'h1, 3'h2, 3'h1,
		3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3};
	localparam logic [2:0] IFB_SRC_FBIT [IFB_NSRC] = '{3'h4, 3'h7, 3'h5,
		3'h6, 3'h6, 3'h5, 3'h4, 3'h4, 3'h5, 3'h6, 3'h7};
	localparam logic [2:0] IFB_SRC_EBIT [IFB_NSRC] = '{3'h1, 3'h3, 3'h2,
		3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};

	// Peripheral event pulses, one cycle each, and the two pin levels.
	typedef struct packed {
		logic [1:0] pin;
		logic [1:0] tbase;
		logic adc;
		logic eeprom;
		logic sim;
		logic uart;
		logic [11:0] tmr;
	} ifb_evt_t;

	// Core access to the register window.
	typedef struct packed {
		logic wr;
		logic [2:0] idx;
		logic [7:0] wdata;
	} ifb_req_t;

endpackage : ifb_pkg

// ---- ifb_core_model.sv ----
/*
 * Core model that enters the service of a pending interrupt request.
 * Assumes the bank's request outputs are registered on the same clock.
 */
`timescale 1ns/100ps
module ifb_core_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic [1:0] i_dly,
	input wire logic i_req,
	input wire logic [3:0] i_vec,
	output logic o_ack,
	output logic [7:0] o_cnt,
	output logic [3:0] o_vec
);
	logic [1:0] wait_r;

	// Acks a held request after i_dly cycles, once, then waits it out.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_cnt <= 8'h00;
			o_vec <= 4'h0;
			wait_r <= 2'h0;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			o_cnt <= o_cnt + 8'h01;
			o_vec <= i_vec; // Vector taken on the ack edge.
		end else if (i_req && i_en) begin
			o_ack <= (wait_r == i_dly);
			wait_r <= (wait_r == i_dly) ? 2'h0 : wait_r + 2'h1;
		end else begin
			wait_r <= 2'h0;
		end
	end
endmodule : ifb_core_model

// ---- test_irq_flag_enable_bank.sv ----
/*
 * Self-checking bench for the flag and enable bank, large variant.
 * Assumes the core model is compiled before this file.
 */
`timescale 1ns/100ps
module test_irq_flag_enable_bank;
	import ifb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ifb_req_t req_s = '0;
	ifb_evt_t evt_s = '0;
	logic en = 1'b0;
	logic [1:0] dly = 2'h0;
	logic ack;
	logic [7:0] rdata;
	logic [7:0] rdata_s;
	logic irq_req;
	logic [3:0] irq_vec;
	logic wake;
	logic [7:0] acks;
	logic [3:0] ack_vec;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] mask [8] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h00};
	logic [3:0] want_vec [3] = '{4'h3, 4'h4, 4'h5};

	// Clock at 250 MHz.
	always #2 clk = ~clk;

	ifb_bank #(.LARGE_VARIANT(1'b1)) ifb_bank_i (.I_CLK(clk),
		.I_SYS_RST(rst), .I_REG(req_s), .I_EVT(evt_s), .I_IRQ_ACK(ack),
		.O_RDATA(rdata), .O_IRQ_REQ(irq_req), .O_IRQ_VEC(irq_vec),
		.O_WAKE(wake));
	ifb_core_model ifb_core_model_i (.i_clk(clk), .i_rst(rst), .i_en(en),
		.i_dly(dly), .i_req(irq_req), .i_vec(irq_vec), .o_ack(ack),
		.o_cnt(acks), .o_vec(ack_vec));

	// Smaller variant, used only to read back every register index, its narrower third register included.
	if (1'b1) begin : g_small
		ifb_bank #(.LARGE_VARIANT(1'b0)) ifb_bank_i (.I_CLK(clk),
			.I_SYS_RST(rst), .I_REG(req_s), .I_EVT(evt_s), .I_IRQ_ACK(1'b0),
			.O_RDATA(rdata_s), .O_IRQ_REQ(), .O_IRQ_VEC(), .O_WAKE());
	end

	task automatic close_out;
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_byte

	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		@(posedge clk);
		req_s <= '{wr: 1'b1, idx: idx, wdata: d};
		@(posedge clk);
		req_s.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
		@(posedge clk);
		req_s.idx <= idx;
		@(posedge clk);
		#1;
		check_byte(rdata, exp);
	endtask : rd

	// Pulses event lines for one cycle and keeps the pin levels.
	task automatic pulse(input ifb_evt_t e);
		@(posedge clk);
		evt_s <= e | {evt_s.pin, 18'h0};
		@(posedge clk);
		evt_s <= {evt_s.pin, 18'h0};
	endtask : pulse

	// Waits, bounded, for one service entry and checks its vector.
	task automatic serve(input logic [3:0] v);
		logic [7:0] n;
		n = acks;
		for (int i = 0; i < 20 && acks == n; i++) @(posedge clk);
		#1;
		check_byte(acks, n + 8'h01);
		check_byte({4'h0, ack_vec}, {4'h0, v});
	endtask : serve

	// Cycle ceiling that cuts a hung run short.
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			mismatches++;
			close_out();
		end
	end

	// Main sequence: reset, access kinds, edges, events and service.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
		for (int i = 0; i < 8; i++) wr(i[2:0], 8'hff);
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], mask[i]);
			check_byte(rdata_s, i == 3 ? IFB_MASK_CC_SMALL : mask[i]);
		end
		for (int i = 7; i >= 0; i--) wr(i[2:0], 8'h00);
		for (int i = 0; i < 7; i++) rd(i[2:0], 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(IFB_IDX_EDGE, {4'h0, s[1:0], s[1:0]});
			@(posedge clk);
			evt_s.pin <= 2'h3;
			rd(IFB_IDX_CA, {3'h0, s[0], 4'h0});
			rd(IFB_IDX_CB, {s[0], 7'h0});
			wr(IFB_IDX_CA, 8'h00);
			wr(IFB_IDX_CB, 8'h00);
			@(posedge clk);
			evt_s.pin <= 2'h0;
			rd(IFB_IDX_CA, {3'h0, s[1], 4'h0});
			rd(IFB_IDX_CB, {s[1], 7'h0});
			wr(IFB_IDX_CA, 8'h00);
			wr(IFB_IDX_CB, 8'h00);
		end
		wr(IFB_IDX_EDGE, 8'h00);
		wr(IFB_IDX_CA, 8'h0e);
		wr(IFB_IDX_CB, 8'h0f);
		wr(IFB_IDX_CC, 8'h0f);
		pulse('{tbase: 2'h2, adc: 1'b1, eeprom: 1'b1, default: '0});
		#1;
		check_bit(wake, 1'b1);
		@(posedge clk);
		#1;
		check_bit(wake, 1'b0);
		check_bit(irq_req, 1'b0);
		rd(IFB_IDX_CA, 8'h4e);
		rd(IFB_IDX_CB, 8'h6f);
		pulse('{adc: 1'b1, default: '0});
		#1;
		check_bit(wake, 1'b0);
		@(posedge clk);
		#1;
		check_bit(irq_req, 1'b0);
		en <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			dly <= k[1:0];
			wr(IFB_IDX_CA, k == 0 ? 8'h4f : 8'h0f);
			serve(want_vec[k]);
			rd(IFB_IDX_CA, 8'h0e);
		end
		rd(IFB_IDX_CB, 8'h0f);
		pulse('{sim: 1'b1, uart: 1'b1, default: '0});
		rd(IFB_IDX_CC, 8'hcf);
		check_bit(irq_req, 1'b0);
		wr(IFB_IDX_CC, 8'h00);
		wr(IFB_IDX_CB, 8'h4b);
		wr(IFB_IDX_CA, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		check_bit(irq_req, 1'b0);
		rd(IFB_IDX_CB, 8'h4b);
		wr(IFB_IDX_MFA, 8'h01);
		pulse('{tmr: 12'h10f, default: '0});
		serve(4'h6);
		rd(IFB_IDX_MFA, 8'hf1);
		rd(IFB_IDX_MFC, 8'h10);
		close_out();
	end
endmodule : test_irq_flag_enable_bank
